// >>> logic/gpp_port.sv
// two 5-pin general-purpose ports with latch, direction, pull-up and peripheral sharing
//
// Contract
// - direction bit one means output, zero input
// - output pin without peripheral drives latch bit
// - writes always load latch, inputs not driven
// - ordinary read of output pin returns latch
// - input pin reads level; rmw reads latch
// - peripheral output enable replaces latch on pin
// - peripheral-driven pin reads level; rmw latch
// - reads give pin level despite peripheral input
// - reset clears every direction bit
// - float standby: pins hi-z, inputs forced low
// - serial wake pins stay open when enabled
// - no float: standby keeps pins untouched
// - pull-up bit connects internal pull-up
// - pull-up off while pin drives low
// - open-drain pin releases on one
// - first port pin c pull-up bit inert
// - first port bits zero to four used
// - triggers routed from pin d or alternate
// - second port behaves like the first
// - second port bits zero to four used
// - counter clock wake pin stays open
`include "gpp_map.svh"

module gpp_port
	import gpp_pkg::*;
#(
	parameter gpp_pins_t P1_OPEN_DRAIN = 5'h00, // pins of port 1 that are n-channel open drain
	parameter gpp_pins_t P2_OPEN_DRAIN = 5'h00 // pins of port 2 that are n-channel open drain
) (
	input wire logic clock_in, // system clock, 25 mhz
	input wire logic rstn_in, // cpu reset, async, active low
	input wire gpp_addr_t reg_addr_in, // register address
	input wire gpp_byte_t reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	input wire logic reg_rmw_in, // read belongs to a read-modify-write
	output gpp_byte_t reg_rdata_out, // read data, cycle after strobe
	input wire logic standby_pin_float_in, // float bit of standby control
	input wire logic standby_active_in, // device is in stop or watch mode
	input wire logic serial_data_wake_en_in, // wake interrupt enabled on port 1 pin a
	input wire logic serial_clock_wake_en_in, // wake interrupt enabled on port 1 pin d
	input wire logic composite_clock_wake_en_in, // wake interrupt enabled on port 2 pin e
	input wire logic system_config_trig_alt_in, // 1 takes triggers from alternate pin
	input wire logic alternate_trigger_pin_in, // level of the alternate trigger pin
	input wire logic serial_data_out_in, // serial data output value
	input wire logic serial_data_out_en_in, // serial data output enable
	input wire logic serial_clock_io_in, // serial clock output value
	input wire logic serial_clock_io_en_in, // serial clock output enable
	input wire logic pulse_timer_out_in, // pulse timer output value
	input wire logic pulse_timer_out_en_in, // pulse timer output enable
	input wire logic pulse_gen_out_a_in, // pulse generator a value
	input wire logic pulse_gen_out_a_en_in, // pulse generator a enable
	input wire logic pulse_gen_out_b_in, // pulse generator b value
	input wire logic pulse_gen_out_b_en_in, // pulse generator b enable
	input wire logic composite_timer_out_a_in, // composite timer a value
	input wire logic composite_timer_out_a_en_in, // composite timer a enable
	input wire logic composite_timer_out_b_in, // composite timer b value
	input wire logic composite_timer_out_b_en_in, // composite timer b enable
	input wire gpp_pins_t p1_pin_in, // port 1 pin levels
	output gpp_pins_t p1_pin_out, // port 1 pin drive values
	output gpp_pins_t p1_pin_oe_out, // port 1 pin drive enables
	output gpp_pins_t p1_pullup_out, // port 1 pull-up connect
	input wire gpp_pins_t p2_pin_in, // port 2 pin levels
	output gpp_pins_t p2_pin_out, // port 2 pin drive values
	output gpp_pins_t p2_pin_oe_out, // port 2 pin drive enables
	output gpp_pins_t p2_pullup_out, // port 2 pull-up connect
	output logic serial_data_in_out, // serial data input level to peripheral
	output logic serial_clock_in_out, // serial clock input level to peripheral
	output logic debug_wire_in_out, // debug wire level to peripheral
	output logic pulse_timer_trigger_out, // routed pulse timer trigger
	output logic converter_trigger_out, // routed converter trigger
	output logic composite_timer_clock_out // composite timer clock level
);

	gpp_pins_t p1_latch_q, p1_dir_q, p1_pull_q;
	gpp_pins_t p2_latch_q, p2_dir_q, p2_pull_q;
	gpp_pins_t p1_meta_q, p1_sync_q, p2_meta_q, p2_sync_q;
	logic alt_meta_q, alt_sync_q;
	gpp_byte_t rdata_q;

	// address decode
	wire logic sel_p1_latch = reg_addr_in == `GPP_OFS_P1_LATCH;
	wire logic sel_p1_dir = reg_addr_in == `GPP_OFS_P1_DIR;
	wire logic sel_p1_pull = reg_addr_in == `GPP_OFS_P1_PULL;
	wire logic sel_p2_latch = reg_addr_in == `GPP_OFS_P2_LATCH;
	wire logic sel_p2_dir = reg_addr_in == `GPP_OFS_P2_DIR;
	wire logic sel_p2_pull = reg_addr_in == `GPP_OFS_P2_PULL;
	wire gpp_pins_t wr_bits = reg_wdata_in[`GPP_PINS-1:0];

	// register writes; upper three bits have no pin and are not stored
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			p1_latch_q <= `GPP_RST_LATCH;
			p1_dir_q <= `GPP_RST_DIR;
			p1_pull_q <= `GPP_RST_PULL;
			p2_latch_q <= `GPP_RST_LATCH;
			p2_dir_q <= `GPP_RST_DIR;
			p2_pull_q <= `GPP_RST_PULL;
		end else if (reg_wr_in) begin
			if (sel_p1_latch) p1_latch_q <= wr_bits;
			if (sel_p1_dir) p1_dir_q <= wr_bits;
			if (sel_p1_pull) p1_pull_q <= wr_bits;
			if (sel_p2_latch) p2_latch_q <= wr_bits;
			if (sel_p2_dir) p2_dir_q <= wr_bits;
			if (sel_p2_pull) p2_pull_q <= wr_bits;
		end
	end

	// pin synchronisers; first stage is read only by the second
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			p1_meta_q <= 5'h00;
			p1_sync_q <= 5'h00;
			p2_meta_q <= 5'h00;
			p2_sync_q <= 5'h00;
			alt_meta_q <= 1'b0;
			alt_sync_q <= 1'b0;
		end else begin
			p1_meta_q <= p1_pin_in;
			p1_sync_q <= p1_meta_q;
			p2_meta_q <= p2_pin_in;
			p2_sync_q <= p2_meta_q;
			alt_meta_q <= alternate_trigger_pin_in;
			alt_sync_q <= alt_meta_q;
		end
	end

	// peripheral outputs gathered per pin position
	wire gpp_pins_t p1_per_oe = {pulse_timer_out_en_in, serial_clock_io_en_in, 1'b0,
		serial_data_out_en_in, 1'b0};
	wire gpp_pins_t p1_per_val = {pulse_timer_out_in, serial_clock_io_in, 1'b0,
		serial_data_out_in, 1'b0};
	wire gpp_pins_t p2_per_oe = {1'b0, composite_timer_out_b_en_in, composite_timer_out_a_en_in,
		pulse_gen_out_b_en_in, pulse_gen_out_a_en_in};
	wire gpp_pins_t p2_per_val = {1'b0, composite_timer_out_b_in, composite_timer_out_a_in,
		pulse_gen_out_b_in, pulse_gen_out_a_in};

	// standby floating; when the float bit is low nothing changes in standby
	wire logic float_now = standby_pin_float_in & standby_active_in;
	wire gpp_pins_t p1_keep_open = {1'b0, serial_clock_wake_en_in, 2'b00,
		serial_data_wake_en_in};
	wire gpp_pins_t p2_keep_open = {composite_clock_wake_en_in, 4'h0};
	wire gpp_pins_t p1_in_gate = float_now ? p1_keep_open : 5'h1f;
	wire gpp_pins_t p2_in_gate = float_now ? p2_keep_open : 5'h1f;
	wire gpp_pins_t p1_level = p1_sync_q & p1_in_gate;
	wire gpp_pins_t p2_level = p2_sync_q & p2_in_gate;

	// drive value: peripheral wins over latch when its enable is set
	wire gpp_pins_t p1_val = (p1_per_oe & p1_per_val) | (~p1_per_oe & p1_latch_q);
	wire gpp_pins_t p2_val = (p2_per_oe & p2_per_val) | (~p2_per_oe & p2_latch_q);
	wire gpp_pins_t p1_drive = p1_dir_q | p1_per_oe;
	wire gpp_pins_t p2_drive = p2_dir_q | p2_per_oe;
	// open-drain pins only ever pull low
	wire gpp_pins_t p1_oe = p1_drive & ~(P1_OPEN_DRAIN & p1_val) & {5{~float_now}};
	wire gpp_pins_t p2_oe = p2_drive & ~(P2_OPEN_DRAIN & p2_val) & {5{~float_now}};

	assign p1_pin_out = p1_val;
	assign p2_pin_out = p2_val;
	assign p1_pin_oe_out = p1_oe;
	assign p2_pin_oe_out = p2_oe;

	// pull-up drops while the pin drives low; pin c of port 1 has none
	localparam gpp_pins_t P1_PULL_MASK = 5'h1b;
	assign p1_pullup_out = p1_pull_q & ~(p1_oe & ~p1_val) & P1_PULL_MASK;
	assign p2_pullup_out = p2_pull_q & ~(p2_oe & ~p2_val);

	// read value per bit: latch for plain outputs or rmw, else synchronised level
	wire gpp_pins_t p1_use_latch = {5{reg_rmw_in}} | (p1_dir_q & ~p1_per_oe);
	wire gpp_pins_t p2_use_latch = {5{reg_rmw_in}} | (p2_dir_q & ~p2_per_oe);
	wire gpp_pins_t p1_rd = (p1_use_latch & p1_latch_q) | (~p1_use_latch & p1_level);
	wire gpp_pins_t p2_rd = (p2_use_latch & p2_latch_q) | (~p2_use_latch & p2_level);

	// read mux; unmapped addresses read zero
	wire gpp_byte_t rd_mux = sel_p1_latch ? {3'h0, p1_rd} :
		sel_p1_dir ? {3'h0, p1_dir_q} :
		sel_p1_pull ? {3'h0, p1_pull_q} :
		sel_p2_latch ? {3'h0, p2_rd} :
		sel_p2_dir ? {3'h0, p2_dir_q} :
		sel_p2_pull ? {3'h0, p2_pull_q} : 8'h00;

	// read data held for exactly the cycle after the strobe
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) rdata_q <= `GPP_RST_RDATA;
		else rdata_q <= reg_rd_in ? rd_mux : 8'h00;
	end
	assign reg_rdata_out = rdata_q;

	// peripheral input levels, blocked like the read path during float standby
	assign serial_data_in_out = p1_level[`GPP_BIT_A];
	assign debug_wire_in_out = p1_level[`GPP_BIT_C];
	assign serial_clock_in_out = p1_level[`GPP_BIT_D];
	assign composite_timer_clock_out = p2_level[`GPP_BIT_E];
	// alternate trigger pin is not floated here; its own port owns that
	wire logic trig_src = system_config_trig_alt_in ? alt_sync_q : p1_level[`GPP_BIT_D];
	assign pulse_timer_trigger_out = trig_src;
	assign converter_trigger_out = trig_src;

endmodule

// >>> common/gpp_map.svh
// register offsets, field positions and reset values of the two-port gpio block
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

`define GPP_ADDR_W 3
`define GPP_OFS_P1_LATCH 3'h0
`define GPP_OFS_P1_DIR 3'h1
`define GPP_OFS_P1_PULL 3'h2
`define GPP_OFS_P2_LATCH 3'h3
`define GPP_OFS_P2_DIR 3'h4
`define GPP_OFS_P2_PULL 3'h5

`define GPP_PINS 5
`define GPP_RST_LATCH 5'h00
`define GPP_RST_DIR 5'h00
`define GPP_RST_PULL 5'h00
`define GPP_RST_RDATA 8'h00

`define GPP_BIT_A 0
`define GPP_BIT_B 1
`define GPP_BIT_C 2
`define GPP_BIT_D 3
`define GPP_BIT_E 4

`endif

// >>> common/gpp_pkg.sv
// types shared by the two-port gpio block
package gpp_pkg;
	typedef logic [4:0] gpp_pins_t;
	typedef logic [7:0] gpp_byte_t;
	typedef logic [2:0] gpp_addr_t;
endpackage

// >>> testbench/gpp_port_props.sv
// concurrent checks on the ports of the two-port gpio block
module gpp_port_props import gpp_pkg::*; #(
	parameter gpp_pins_t P1_OPEN_DRAIN = 5'h00 // open-drain pins of port 1
) (
	input wire logic clock_in, rstn_in, reg_wr_in, reg_rd_in, // clock, reset, strobes
	input wire gpp_addr_t reg_addr_in, // register address
	input wire gpp_byte_t reg_wdata_in, reg_rdata_out, // write and read data
	input wire logic standby_pin_float_in, standby_active_in, // standby float controls
	input wire logic serial_data_out_in, serial_data_out_en_in, // shared serial output
	input wire logic system_config_trig_alt_in, alternate_trigger_pin_in, // trigger routing
	input wire logic pulse_timer_trigger_out, converter_trigger_out, // routed triggers
	input wire gpp_pins_t p1_pin_out, p1_pin_oe_out, p1_pullup_out, // port 1 pin side
	input wire gpp_pins_t p2_pin_out, p2_pin_oe_out, p2_pullup_out // port 2 pin side
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic flt = standby_pin_float_in & standby_active_in; // floated standby
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	// read data stand only in the cycle after the strobe, upper bits never set
	read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00) else $error("idle read data");
	read_upper_a: assert property (reg_rd_in |=> reg_rdata_out[7:5] == 3'h0)
		else $error("upper read bits set");
	dir_readback_a: assert property (reg_wr_in && reg_addr_in == 3'h1 ##1 reg_rd_in &&
		reg_addr_in == 3'h1 |=> reg_rdata_out == {3'h0, $past(reg_wdata_in[4:0], 2)})
		else $error("direction readback");
	// pin a has no peripheral and is push-pull, so its enable is the direction bit
	dir_drive_a: assert property (reg_wr_in && reg_addr_in == 3'h1 && !flt ##1 !flt |->
		p1_pin_oe_out[0] == $past(reg_wdata_in[0])) else $error("direction not driven");
	latch_drive_a: assert property (reg_wr_in && reg_addr_in == 3'h0 |=>
		p1_pin_out[0] == $past(reg_wdata_in[0])) else $error("latch not on pin");
	periph_route_a: assert property (serial_data_out_en_in |->
		p1_pin_out[1] == serial_data_out_in) else $error("peripheral not routed");
	float_hiz_a: assert property (flt |-> (p1_pin_oe_out | p2_pin_oe_out) == 5'h00)
		else $error("pin driven in floated standby");
	low_pull_off_a: assert property (((p1_pin_oe_out & ~p1_pin_out & p1_pullup_out) |
		(p2_pin_oe_out & ~p2_pin_out & p2_pullup_out)) == 5'h00) else $error("pull-up on low pin");
	debug_pull_a: assert property (!p1_pullup_out[2]) else $error("pin c pull-up on");
	open_drain_a: assert property ((p1_pin_out & p1_pin_oe_out & P1_OPEN_DRAIN) == 5'h00)
		else $error("open drain driven high");
	// synchroniser delay is covered by three stable samples
	trig_route_a: assert property ((system_config_trig_alt_in &&
		$stable(alternate_trigger_pin_in))[*3] |->
		{pulse_timer_trigger_out, converter_trigger_out} == {2{alternate_trigger_pin_in}})
		else $error("trigger not routed");
	cover property (flt ##1 reg_rd_in);
	cover property (reg_wr_in ##1 reg_rd_in);
	cover property (serial_data_out_en_in && reg_rd_in);
endmodule

bind gpp_port gpp_port_props #(.P1_OPEN_DRAIN(P1_OPEN_DRAIN)) i_props (.clock_in, .rstn_in,
	.reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .standby_pin_float_in,
	.standby_active_in, .serial_data_out_in, .serial_data_out_en_in, .system_config_trig_alt_in,
	.alternate_trigger_pin_in, .pulse_timer_trigger_out, .converter_trigger_out, .p1_pin_out,
	.p1_pin_oe_out, .p1_pullup_out, .p2_pin_out, .p2_pin_oe_out, .p2_pullup_out);

// >>> testbench/gpp_board.sv
// board model: resolves each pin from drive, internal pull-up and far-side level
module gpp_board import gpp_pkg::*; (
	input wire gpp_pins_t drive_in, // pin drive values from the port
	input wire gpp_pins_t oe_in, // pin drive enables
	input wire gpp_pins_t pull_in, // internal pull-up connect
	input wire gpp_pins_t ext_in, // weak far-side level
	output gpp_pins_t level_out // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ns;
	// a driven pin wins; a released pin rests on the pull-up or the weak external level
	assign level_out = (oe_in & drive_in) | (~oe_in & (pull_in | ext_in));
endmodule

// >>> testbench/testbench.sv
// self-checking bench: random register and pin traffic against a bench model
module testbench import gpp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0, reg_rmw_in = 0;
	gpp_addr_t reg_addr_in = 3'h0;
	gpp_byte_t reg_wdata_in = 8'h00, reg_rdata_out;
	logic [13:0] per = 14'h0000; // peripheral values and enables
	logic [6:0] ctl = 7'h00; // float, standby, wake enables, trigger select, alternate pin
	gpp_pins_t ext1 = 5'h00, ext2 = 5'h00, lv1, lv2, o1, oe1, pu1, o2, oe2, pu2, m1, m2;
	logic si, sc, dw, ct, tpt, cvt; // peripheral input levels and routed triggers
	logic [31:0] seed = 32'he427de59, r;
	int regs[8], miscompares = 0, samples_checked = 0, cycles = 0;
	wire logic fl = ctl[0] & ctl[1];
	always #20 clock_in = ~clock_in;
	// far side: weak external level, overridden by the pull-up and by the pin driver
	gpp_board i_board1 (.drive_in(o1), .oe_in(oe1), .pull_in(pu1), .ext_in(ext1), .level_out(lv1));
	gpp_board i_board2 (.drive_in(o2), .oe_in(oe2), .pull_in(pu2), .ext_in(ext2), .level_out(lv2));
	gpp_port #(.P1_OPEN_DRAIN(5'h04)) i_dut (.clock_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rmw_in, .reg_rdata_out, .standby_pin_float_in(ctl[0]),
		.standby_active_in(ctl[1]), .serial_data_wake_en_in(ctl[2]),
		.serial_clock_wake_en_in(ctl[3]), .composite_clock_wake_en_in(ctl[4]),
		.system_config_trig_alt_in(ctl[5]), .alternate_trigger_pin_in(ctl[6]),
		.serial_data_out_in(per[0]), .serial_data_out_en_in(per[1]), .serial_clock_io_in(per[2]),
		.serial_clock_io_en_in(per[3]), .pulse_timer_out_in(per[4]), .pulse_timer_out_en_in(per[5]),
		.pulse_gen_out_a_in(per[6]), .pulse_gen_out_a_en_in(per[7]), .pulse_gen_out_b_in(per[8]),
		.pulse_gen_out_b_en_in(per[9]), .composite_timer_out_a_in(per[10]),
		.composite_timer_out_a_en_in(per[11]), .composite_timer_out_b_in(per[12]),
		.composite_timer_out_b_en_in(per[13]), .p1_pin_in(lv1), .p1_pin_out(o1),
		.p1_pin_oe_out(oe1), .p1_pullup_out(pu1), .p2_pin_in(lv2), .p2_pin_out(o2),
		.p2_pin_oe_out(oe2), .p2_pullup_out(pu2), .serial_data_in_out(si),
		.serial_clock_in_out(sc), .debug_wire_in_out(dw), .pulse_timer_trigger_out(tpt),
		.converter_trigger_out(cvt), .composite_timer_clock_out(ct));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// bench model of each port: peripheral enables, pin values, drive enables
	function automatic gpp_pins_t pen(int p);
		return p ? {1'b0, per[13], per[11], per[9], per[7]} : {per[5], per[3], 1'b0, per[1], 1'b0};
	endfunction
	function automatic gpp_pins_t val(int p);
		gpp_pins_t pv;
		pv = p ? {1'b0, per[12], per[10], per[8], per[6]} : {per[4], per[2], 1'b0, per[0], 1'b0};
		return (pen(p) & pv) | (~pen(p) & regs[p * 3][4:0]);
	endfunction
	// open-drain pin c of port 1 only ever pulls low
	function automatic gpp_pins_t drv(int p);
		return (pen(p) | regs[p * 3 + 1][4:0]) & ~((p ? 5'h00 : 5'h04) & val(p)) & ~{5{fl}};
	endfunction
	// level seen inside the port: board resolution, then standby blocking
	function automatic gpp_pins_t lvl(int p);
		gpp_pins_t lv, keep;
		lv = (drv(p) & val(p)) | (~drv(p) & ((regs[p * 3 + 2][4:0] & (p ? 5'h1f : 5'h1b)) |
			(p ? ext2 : ext1)));
		keep = p ? {ctl[4], 4'h0} : {1'b0, ctl[3], 2'h0, ctl[2]};
		return lv & ~({5{fl}} & ~keep);
	endfunction
	function automatic gpp_byte_t exp_rd(int a, logic m);
		gpp_pins_t sel;
		int p;
		p = a / 3;
		if (a > 5 || a % 3 != 0) return (a > 5) ? 8'h00 : {3'h0, regs[a][4:0]};
		sel = {5{m}} | (regs[a + 1][4:0] & ~pen(p));
		return {3'h0, (sel & regs[a][4:0]) | (~sel & lvl(p))};
	endfunction
	task automatic check(string n, gpp_byte_t e, gpp_byte_t g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(int a, gpp_byte_t d);
		@(posedge clock_in);
		{reg_rd_in, reg_wr_in, reg_addr_in, reg_wdata_in} <= {2'b01, a[2:0], d};
		if (a < 6) regs[a] = d[4:0];
	endtask
	// leaves a write strobe up to the read edge, so write and read run back to back
	task automatic rd(int a, logic m, string n);
		gpp_byte_t e;
		@(posedge clock_in);
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_rmw_in} <= {2'b01, a[2:0], m};
		e = exp_rd(a, m);
		@(posedge clock_in);
		reg_rd_in <= 0;
		#1 check(n, e, reg_rdata_out);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(posedge clock_in);
		rstn_in <= 1;
		for (int i = 0; i < 30; i++) begin
			// every input change lands right at a rising edge
			@(posedge clock_in);
			if (i == 15) begin
				rstn_in <= 0;
				regs = '{default: 0};
				@(posedge clock_in);
				rstn_in <= 1;
			end
			r = rnd();
			{per, ctl, ext1, ext2} <= r[30:0];
			if (i > 0) begin
				r = rnd();
				wr(r[10:8], r[7:0]);
				rd(r[10:8], 1'b1, "readback");
			end
			// let pin levels cross the two-stage synchroniser
			repeat (3) @(posedge clock_in);
			check("port1 drive", {3'h0, drv(0)}, {3'h0, oe1});
			check("port2 drive", {3'h0, drv(1)}, {3'h0, oe2});
			m1 = lvl(0);
			m2 = lvl(1);
			check("peripheral inputs", {4'h0, m1[0], m1[2], m1[3], m2[4]}, {4'h0, si, dw, sc, ct});
			check("triggers", {6'h00, {2{ctl[5] ? ctl[6] : m1[3]}}}, {6'h00, tpt, cvt});
			for (int a = 0; a < 8; a++) begin
				r = rnd();
				rd(a, r[0], "register read");
			end
			$display("test %0d done", i);
		end
		complete_run;
	end
endmodule
